// ### core/thd_pkg.sv
// Constants for the current harmonic distortion alarm.
// Assumes a 10 MHz clock and a 5 ms measurement tick.
package thd_pkg;
  localparam int CLK_NS   = 100;
  localparam int STAMP_NS = 1000000;
  localparam int TICK_MS  = 5;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int LOG_DEPTH = 12;

  localparam logic [7:0] A_MODE  = 8'h00;
  localparam logic [7:0] A_MAG   = 8'h04;
  localparam logic [7:0] A_DIS   = 8'h08;
  localparam logic [7:0] A_THR0  = 8'h0C;
  localparam logic [7:0] A_DLY0  = 8'h18;
  localparam logic [7:0] A_TEST  = 8'h24;
  localparam logic [7:0] A_STAT  = 8'h28;
  localparam logic [7:0] A_CNT0  = 8'h2C;
  localparam logic [7:0] A_TIME  = 8'h38;
  localparam logic [7:0] A_LSEL  = 8'h3C;
  localparam logic [7:0] A_LCNT  = 8'h40;
  localparam logic [7:0] A_LREC0 = 8'h44;

  localparam logic [2:0] MODE_ON   = 3'h1;
  localparam logic [2:0] MODE_BLK  = 3'h2;
  localparam logic [2:0] MODE_TBLK = 3'h4;
  localparam logic [2:0] MODE_OFF  = 3'h5;
  localparam logic [1:0] MAG_AMP   = 2'h1;
  localparam logic [1:0] MAG_POW   = 2'h2;

  localparam logic [13:0] THR_RST  = 14'h03E8;
  localparam logic [18:0] DLY_RST  = 19'h007D0;
  localparam logic [18:0] DLY_MAX  = 19'h57E40;
  localparam logic [3:0]  TEST_RST = 4'hC;
  localparam int TST_FORCE = 0;
  localparam int TST_SW    = 1;
  localparam int TST_ON    = 2;
  localparam int TST_OFF   = 3;

  localparam logic [31:0] SCALE      = 32'h00002710;
  localparam logic [31:0] SCALE_SQ   = 32'h05F5E100;
  localparam logic [31:0] HYS_NUM    = 32'h00000061;
  localparam logic [31:0] HYS_DEN    = 32'h00000064;
  localparam logic [31:0] HYS_NUM_SQ = 32'h000024C1;
  localparam logic [31:0] HYS_DEN_SQ = 32'h00002710;

  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START  = 2'h1;
  localparam logic [1:0] COND_ALARM  = 2'h2;
  localparam logic [1:0] COND_BLK    = 2'h3;
  localparam logic [2:0] EV_BLOCKED  = 3'h6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### core/thd_alarm.sv
// Current harmonic distortion alarm with AXI4-Lite registers.
// Assumes meas_tick pulses every 5 ms and the measurement ports hold between ticks.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

// What this block does
// - Mode setting On, Blocked, Test, Test/Blocked, Off; resets to On.
// - One selector: amplitude ratio (1, default) or power ratio (2).
// - Mode and selector ignore the active setting group.
// - Per-element disable bit, 0 enabled; disabled element never alarms.
// - Per-element threshold in 0.01 % units, reset 10.00 %.
// - Phase picks up on any phase over threshold; residuals on their own.
// - All three phases share one threshold.
// - Drop-out only below 97 % of threshold, fixed.
// - Pick-up without blocking raises start and runs the delay.
// - Blocking is sampled at each tick before pick-up decisions.
// - Pick-up under blocking raises blocked instead of start.
// - Blocking after start clears start and the timer.
// - Blocking produces an event and a record with current values.
// - Stage forcing lets a software switch drive blocking.
// - Per-element definite delay, 5 ms steps, up to 1800 s, reset 10 s.
// - Read-only condition: 0 Normal, 1 Start, 2 Alarm, 3 Blocked.
// - Read-only copy of effective mode, same coding.
// - ON/OFF events for starts, alarms, blocked; ON/OFF store choice.
// - Twelve newest ON records: stamp, identity, phase values, group.
// - Power ratio is harmonics 2..31 power over fundamental power.
// - Clearable start, alarm, blocked counters; 1 ms time stamps.
module thd_alarm #(
  parameter int MS_CYCLES = thd_pkg::STAMP_NS / thd_pkg::CLK_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        meas_tick,
  input  wire logic [31:0] fund_sq_l1,
  input  wire logic [31:0] fund_sq_l2,
  input  wire logic [31:0] fund_sq_l3,
  input  wire logic [31:0] fund_sq_r1,
  input  wire logic [31:0] fund_sq_r2,
  input  wire logic [31:0] harm_sq_l1,
  input  wire logic [31:0] harm_sq_l2,
  input  wire logic [31:0] harm_sq_l3,
  input  wire logic [31:0] harm_sq_r1,
  input  wire logic [31:0] harm_sq_r2,
  input  wire logic        block_in,
  input  wire logic [2:0]  setting_group,
  output logic [2:0]       start_out,
  output logic [2:0]       alarm_out,
  output logic             blocked_out,
  output logic             event_valid,
  output logic [2:0]       event_id,
  output logic             event_on
);
  logic [2:0]  mode_reg;
  logic [1:0]  mag_reg;
  logic [2:0]  dis_reg;
  logic [13:0] thr_reg [3];
  logic [18:0] dly_reg [3];
  logic [3:0]  test_reg;
  logic [18:0] tmr_reg [3];
  logic [2:0]  pick_reg;
  logic        blk_s1_reg;
  logic        blk_s2_reg;
  logic [31:0] hs [5];
  logic [31:0] f2 [5];
  logic [4:0]  hit;
  logic [2:0]  pick_next;
  logic [2:0]  start_next;
  logic        blk_now;
  logic        off;
  logic [6:0]  sig;
  logic [6:0]  sig_prev_reg;
  logic [6:0]  pend_reg;
  logic [6:0]  pend_clr;
  logic [2:0]  sel;
  logic        any;
  logic        log_we;
  logic [31:0] ev_cnt_reg [3];
  logic [31:0] ms_div_reg;
  logic [31:0] ms_reg;
  logic [31:0] rec_ts [thd_pkg::LOG_DEPTH];
  logic [5:0]  rec_tag [thd_pkg::LOG_DEPTH];
  logic [31:0] rec_d [thd_pkg::LOG_DEPTH][3];
  logic [3:0]  wptr_reg;
  logic [3:0]  lcnt_reg;
  logic [3:0]  lsel_reg;
  logic [1:0]  cond;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_en;
  logic [32:0] wr_old;
  logic [32:0] rd_word;
  logic [31:0] wv;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign hs[0] = harm_sq_l1;
  assign hs[1] = harm_sq_l2;
  assign hs[2] = harm_sq_l3;
  assign hs[3] = harm_sq_r1;
  assign hs[4] = harm_sq_r2;
  assign f2[0] = fund_sq_l1;
  assign f2[1] = fund_sq_l2;
  assign f2[2] = fund_sq_l3;
  assign f2[3] = fund_sq_r1;
  assign f2[4] = fund_sq_r2;

  // Ratios compared by cross-multiplying, so no divider is needed
  function automatic logic over(input logic [31:0] h, input logic [31:0] f,
                                input logic [13:0] t, input logic pw, input logic held);
    logic [95:0] l;
    logic [95:0] r;
    l = 96'(h) * (pw ? 96'(thd_pkg::SCALE) : 96'(thd_pkg::SCALE_SQ));
    r = 96'(f) * 96'(t);
    if (!pw)
      r = r * 96'(t);
    if (held) begin
      l = l * (pw ? 96'(thd_pkg::HYS_DEN) : 96'(thd_pkg::HYS_DEN_SQ));
      r = r * (pw ? 96'(thd_pkg::HYS_NUM) : 96'(thd_pkg::HYS_NUM_SQ));
      over = l >= r;
    end else begin
      over = l > r;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
  endfunction

  function automatic logic [7:0] at(input logic [7:0] base, input int k);
    at = base + 8'(4 * k);
  endfunction

  // Index of the n-th newest record, n = 0 newest
  function automatic int rec_idx(input logic [3:0] wp, input logic [3:0] n);
    rec_idx = (int'(wp) + thd_pkg::LOG_DEPTH - 1 - int'(n)) % thd_pkg::LOG_DEPTH;
  endfunction

  function automatic logic [32:0] reg_word(input logic [7:0] a);
    logic [31:0] d;
    logic        ok;
    int          ri;
    d = 32'h00000000;
    ok = 1'b1;
    ri = rec_idx(wptr_reg, lsel_reg);
    if (a == thd_pkg::A_MODE)
      d = 32'(mode_reg);
    else if (a == thd_pkg::A_MAG)
      d = 32'(mag_reg);
    else if (a == thd_pkg::A_DIS)
      d = 32'(dis_reg);
    else if (a == thd_pkg::A_TEST)
      d = 32'(test_reg);
    else if (a == thd_pkg::A_STAT)
      d = {15'h0000, blocked_out, 1'b0, alarm_out, 1'b0, start_out, 1'b0, mode_reg, 2'h0, cond};
    else if (a == thd_pkg::A_TIME)
      d = ms_reg;
    else if (a == thd_pkg::A_LSEL)
      d = 32'(lsel_reg);
    else if (a == thd_pkg::A_LCNT)
      d = 32'(lcnt_reg);
    else if (a == at(thd_pkg::A_LREC0, 0))
      d = (lsel_reg < lcnt_reg) ? rec_ts[ri] : 32'h00000000;
    else if (a == at(thd_pkg::A_LREC0, 1))
      d = (lsel_reg < lcnt_reg) ? 32'(rec_tag[ri]) : 32'h00000000;
    else
      ok = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (a == at(thd_pkg::A_THR0, k)) begin
        d = 32'(thr_reg[k]);
        ok = 1'b1;
      end
      if (a == at(thd_pkg::A_DLY0, k)) begin
        d = 32'(dly_reg[k]);
        ok = 1'b1;
      end
      if (a == at(thd_pkg::A_CNT0, k)) begin
        d = ev_cnt_reg[k];
        ok = 1'b1;
      end
      if (a == at(thd_pkg::A_LREC0, k + 2)) begin
        d = (lsel_reg < lcnt_reg) ? rec_d[ri][k] : 32'h00000000;
        ok = 1'b1;
      end
    end
    reg_word = {ok, d};
  endfunction

  // Blocking pin crosses in through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_s1_reg <= 1'b0;
      blk_s2_reg <= 1'b0;
    end else begin
      blk_s1_reg <= block_in;
      blk_s2_reg <= blk_s1_reg;
    end
  end

  assign off = mode_reg == thd_pkg::MODE_OFF;
  assign blk_now = blk_s2_reg | (test_reg[thd_pkg::TST_FORCE] & test_reg[thd_pkg::TST_SW])
                 | mode_reg == thd_pkg::MODE_BLK | mode_reg == thd_pkg::MODE_TBLK;

  always_comb begin
    for (int c = 0; c < 5; c++)
      hit[c] = over(hs[c], f2[c], thr_reg[c < 3 ? 0 : c - 2], mag_reg == thd_pkg::MAG_POW,
                    pick_reg[c < 3 ? 0 : c - 2]);
    pick_next = off ? 3'h0 : {hit[4], hit[3], |hit[2:0]} & ~dis_reg;
    start_next = pick_next & {3{~blk_now}};
  end

  // Decisions only at the measurement tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pick_reg <= 3'h0;
      start_out <= 3'h0;
      blocked_out <= 1'b0;
    end else if (meas_tick) begin
      pick_reg <= pick_next;
      start_out <= start_next;
      blocked_out <= |pick_next & blk_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_out <= 3'h0;
      for (int e = 0; e < 3; e++)
        tmr_reg[e] <= 19'h00000;
    end else if (meas_tick) begin
      for (int e = 0; e < 3; e++) begin
        if (!start_next[e]) begin
          tmr_reg[e] <= 19'h00000;
          alarm_out[e] <= 1'b0;
        end else if (tmr_reg[e] >= dly_reg[e]) begin
          alarm_out[e] <= 1'b1;
        end else begin
          tmr_reg[e] <= tmr_reg[e] + 19'h00001;
        end
      end
    end
  end

  always_comb begin
    if (blocked_out)
      cond = thd_pkg::COND_BLK;
    else if (|alarm_out)
      cond = thd_pkg::COND_ALARM;
    else if (|start_out)
      cond = thd_pkg::COND_START;
    else
      cond = thd_pkg::COND_NORMAL;
  end

  // Edges queue up and leave one per clock, lowest index first
  assign sig = {blocked_out, alarm_out, start_out};
  always_comb begin
    sel = 3'h0;
    any = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      if (pend_reg[i]) begin
        sel = 3'(i);
        any = 1'b1;
      end
    end
    pend_clr = any ? 7'(1) << sel : 7'h00;
    log_we = any & sig[sel];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_prev_reg <= 7'h00;
      pend_reg <= 7'h00;
      event_valid <= 1'b0;
      event_id <= 3'h0;
      event_on <= 1'b0;
    end else begin
      sig_prev_reg <= sig;
      pend_reg <= (pend_reg & ~pend_clr) | (sig ^ sig_prev_reg);
      event_valid <= any & (sig[sel] ? test_reg[thd_pkg::TST_ON] : test_reg[thd_pkg::TST_OFF]);
      if (any) begin
        event_id <= sel;
        event_on <= sig[sel];
      end
    end
  end

  // Record memory is not reset; the fill count guards the reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= 4'h0;
      lcnt_reg <= 4'h0;
    end else if (log_we) begin
      rec_ts[wptr_reg] <= ms_reg;
      rec_tag[wptr_reg] <= {setting_group, sel};
      for (int k = 0; k < 3; k++)
        rec_d[wptr_reg][k] <= hs[k];
      wptr_reg <= (wptr_reg == 4'(thd_pkg::LOG_DEPTH - 1)) ? 4'h0 : wptr_reg + 4'h1;
      if (lcnt_reg != 4'(thd_pkg::LOG_DEPTH))
        lcnt_reg <= lcnt_reg + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_div_reg <= 32'h00000000;
      ms_reg <= 32'h00000000;
    end else if (ms_div_reg == 32'(MS_CYCLES - 1)) begin
      ms_div_reg <= 32'h00000000;
      ms_reg <= ms_reg + 32'h00000001;
    end else begin
      ms_div_reg <= ms_div_reg + 32'h00000001;
    end
  end

  // A clear and a count in the same cycle leave the counter at 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 3; k++)
        ev_cnt_reg[k] <= 32'h00000000;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (log_we && (k == 2 ? sel == thd_pkg::EV_BLOCKED : int'(sel) / 3 == k && sel != thd_pkg::EV_BLOCKED))
          ev_cnt_reg[k] <= (wr_en && awaddr_reg == at(thd_pkg::A_CNT0, k)) ? 32'h00000001
                           : ev_cnt_reg[k] + 32'h00000001;
        else if (wr_en && awaddr_reg == at(thd_pkg::A_CNT0, k))
          ev_cnt_reg[k] <= 32'h00000000;
      end
    end
  end

  assign wr_en = !awready && !wready && !bvalid;
  // Process form so the lookup follows every register it reads
  always_comb begin
    wr_old = reg_word(awaddr_reg);
    rd_word = reg_word(araddr);
  end
  assign wv = merge(wr_old[31:0], wdata_reg, wstrb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= thd_pkg::MODE_ON;
      mag_reg <= thd_pkg::MAG_AMP;
      dis_reg <= 3'h0;
      test_reg <= thd_pkg::TEST_RST;
      lsel_reg <= 4'h0;
      for (int k = 0; k < 3; k++) begin
        thr_reg[k] <= thd_pkg::THR_RST;
        dly_reg[k] <= thd_pkg::DLY_RST;
      end
    end else if (wr_en) begin
      // Only software writes reach these; the setting group never does
      if (awaddr_reg == thd_pkg::A_MODE && wv[2:0] >= thd_pkg::MODE_ON && wv[2:0] <= thd_pkg::MODE_OFF)
        mode_reg <= wv[2:0];
      if (awaddr_reg == thd_pkg::A_MAG && (wv[1:0] == thd_pkg::MAG_AMP || wv[1:0] == thd_pkg::MAG_POW))
        mag_reg <= wv[1:0];
      if (awaddr_reg == thd_pkg::A_DIS)
        dis_reg <= wv[2:0];
      if (awaddr_reg == thd_pkg::A_TEST)
        test_reg <= wv[3:0];
      if (awaddr_reg == thd_pkg::A_LSEL)
        lsel_reg <= wv[3:0];
      for (int k = 0; k < 3; k++) begin
        if (awaddr_reg == at(thd_pkg::A_THR0, k))
          thr_reg[k] <= wv[13:0];
        if (awaddr_reg == at(thd_pkg::A_DLY0, k) && wv[18:0] <= thd_pkg::DLY_MAX)
          dly_reg[k] <= wv[18:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= thd_pkg::RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awaddr_reg <= awaddr;
        awready <= 1'b0;
      end else if (wr_en) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
        wready <= 1'b0;
      end else if (wr_en) begin
        wready <= 1'b1;
      end
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_old[32] ? thd_pkg::RESP_OKAY : thd_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= thd_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word[31:0];
      rresp <= rd_word[32] ? thd_pkg::RESP_OKAY : thd_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  sequence s_tick_blk;
    meas_tick && blk_now;
  endsequence
  sequence s_tick_free;
    meas_tick && !blk_now;
  endsequence

  property p_mode_default;
    $rose(aresetn) |-> mode_reg == thd_pkg::MODE_ON && mag_reg == thd_pkg::MAG_AMP;
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("bad mode after reset");
  property p_off_quiet;
    meas_tick && off |=> start_out == 3'h0 && alarm_out == 3'h0 && !blocked_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("output active in off mode");
  property p_static;
    $changed(setting_group) && !wr_en |=> $stable(mode_reg) && $stable(mag_reg);
  endproperty
  a_static: assert property (p_static) else $error("setting group moved a static setting");
  property p_disabled;
    meas_tick && dis_reg[2] |=> !start_out[2] && !alarm_out[2];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled element active");
  property p_phase_any;
    meas_tick && hit[1] && !dis_reg[0] && !off |=> pick_reg[0];
  endproperty
  a_phase_any: assert property (p_phase_any) else $error("phase two did not pick up");
  property p_start;
    s_tick_free ##0 pick_next[0] |=> start_out[0];
  endproperty
  a_start: assert property (p_start) else $error("start missing");
  property p_blocked;
    s_tick_blk ##0 (|pick_next) |=> blocked_out && start_out == 3'h0;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked not raised");
  property p_block_clears;
    s_tick_blk |=> start_out == 3'h0 && alarm_out == 3'h0;
  endproperty
  a_block_clears: assert property (p_block_clears) else $error("start survived blocking");
  property p_delay;
    meas_tick && start_next[1] && tmr_reg[1] >= dly_reg[1] |=> alarm_out[1];
  endproperty
  a_delay: assert property (p_delay) else $error("alarm late");
  property p_alarm_start;
    alarm_out[0] |-> start_out[0];
  endproperty
  a_alarm_start: assert property (p_alarm_start) else $error("alarm without start");
  property p_cond;
    blocked_out |-> cond == thd_pkg::COND_BLK;
  endproperty
  a_cond: assert property (p_cond) else $error("condition not blocked");
  property p_blk_event;
    $rose(blocked_out) |-> ##[1:8] (event_id == thd_pkg::EV_BLOCKED && event_on);
  endproperty
  a_blk_event: assert property (p_blk_event) else $error("blocked event missing");
  property p_log_fill;
    log_we && lcnt_reg < 4'(thd_pkg::LOG_DEPTH) |=> lcnt_reg == $past(lcnt_reg) + 4'h1;
  endproperty
  a_log_fill: assert property (p_log_fill) else $error("record count stuck");
  property p_bresp;
    wr_en |=> bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule

// ### tb/meas_source.sv
// Front end model: processing tick and fixed fundamental level.
// Assumes the bench drives harmonic sums and holds them between ticks.
`timescale 1ns/1ps
module meas_source #(
  parameter int PERIOD = 24
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  output logic        meas_tick,
  output logic [31:0] fund_sq
);
  int cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt       <= 0;
      meas_tick <= 1'b0;
    end else begin
      cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_tick <= (cnt == PERIOD - 1); // Fresh spectra each period
    end
  end
  // Fixed fundamental keeps the ratio arithmetic exact
  assign fund_sq = 32'h00002710;
endmodule

// ### tb/testbench.sv
// Self-checking bench: bus, harmonic levels and blocking against a tick model.
// Assumes meas_source ticks every PER cycles with a fixed fundamental.
`timescale 1ns/1ps
module testbench;
  localparam int PER = 24;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, seed = 32'h9AD9;
  logic        block_in = 1'b0, meas_tick, awready, wready, bvalid, arready, rvalid, blocked_out;
  logic [2:0]  setting_group = 3'h0, start_out, alarm_out, st_m = 3'h0, al_m = 3'h0, pk_m = 3'h0, ev_id;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, fund_sq, h[5];
  logic        bl_m = 1'b0, ev_v, ev_o;
  int          mode_m = 1, mag_m = 1, dis_m = 0, test_m = 12, ons = 0;
  int          thr_m[3] = '{1000, 1000, 1000}, dly_m[3] = '{3, 0, 1}, cnt_m[3];
  int          n_errors = 0, tests_run = 0;
  int          onk[3] = '{0, 0, 0}, ev_on[3] = '{0, 0, 0};

  always #50 aclk = ~aclk;

  meas_source #(.PERIOD(PER)) src (.aclk(aclk), .aresetn(aresetn), .meas_tick(meas_tick), .fund_sq(fund_sq));

  thd_alarm #(.MS_CYCLES(10)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas_tick(meas_tick), .fund_sq_l1(fund_sq),
    .fund_sq_l2(fund_sq), .fund_sq_l3(fund_sq), .fund_sq_r1(fund_sq), .fund_sq_r2(fund_sq),
    .harm_sq_l1(h[0]), .harm_sq_l2(h[1]), .harm_sq_l3(h[2]), .harm_sq_r1(h[3]), .harm_sq_r2(h[4]),
    .block_in(block_in), .setting_group(setting_group), .start_out(start_out), .alarm_out(alarm_out),
    .blocked_out(blocked_out), .event_valid(ev_v), .event_id(ev_id), .event_on(ev_o));

  // Stored ON events per class: start, alarm, blocked
  always @(posedge aclk) begin
    if (ev_v && ev_o)
      ev_on[(ev_id == 3'h6) ? 2 : int'(ev_id) / 3]++;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Cross-multiplied so no division rounding creeps in
  function automatic bit pick(longint hs, longint t, bit held);
    if (mag_m == 2) return held ? hs * 1000000 >= 97 * t * 10000 : hs * 10000 > t * 10000;
    return held ? hs * 64'd1000000000000 >= 9409 * t * t * 10000 : hs * 100000000 > t * t * 10000;
  endfunction

  task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && i < 50);
    bready <= 1'b0;
    chk("bresp", {i >= 50, bresp}, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int i = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && i < 50);
    rready <= 1'b0;
    d  = rdata;
    rs = (i >= 50) ? 2'h3 : rresp;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  rs;
    axi_wr(a, d, er);
    axi_rd(a, q, rs);
    chk("readback", {rs, q}, {er, exp});
  endtask

  task automatic model_tick();
    logic       blk;
    logic       pu;
    logic [6:0] prev;
    prev = {bl_m, al_m, st_m};
    blk  = block_in | (test_m[0] & test_m[1]) | mode_m == 2 | mode_m == 4;
    bl_m = 1'b0;
    for (int e = 0; e < 3; e++) begin
      pu = 1'b0;
      for (int c = (e == 0) ? 0 : e + 2; c <= ((e == 0) ? 2 : e + 2); c++) begin
        pu |= pick(h[c], thr_m[e], pk_m[e]);
      end
      pu &= !dis_m[e] && mode_m != 5;
      // Hysteresis follows pick-up, which blocking does not clear
      pk_m[e] = pu;
      if (pu && blk) bl_m = 1'b1;
      if (!pu || blk) begin
        st_m[e]  = 1'b0;
        al_m[e]  = 1'b0;
        cnt_m[e] = 0;
      end else begin
        if (st_m[e]) cnt_m[e]++;
        st_m[e] = 1'b1;
        al_m[e] = cnt_m[e] >= dly_m[e];
      end
    end
    onk[0] += $countones(st_m & ~prev[2:0]);
    onk[1] += $countones(al_m & ~prev[5:3]);
    onk[2] += bl_m & ~prev[6];
    ons = onk[0] + onk[1] + onk[2];
  endtask

  task automatic step();
    logic [31:0] r, d;
    logic [1:0]  rs, cond;
    int          i = 0;
    int          e;
    @(posedge aclk);
    while (!meas_tick && i < 4 * PER) begin
      @(posedge aclk);
      i++;
    end
    model_tick();
    #1;
    chk("start", start_out, st_m);
    chk("alarm", alarm_out, al_m);
    chk("blocked", blocked_out, bl_m);
    @(posedge aclk);
    r = xs();
    foreach (h[c]) h[c] <= (mag_m == 2) ? 940 + xs() % 121 : 90 + xs() % 25;
    block_in      <= r[2:0] == 3'h0; // Leads the next tick by far more than the lead time
    setting_group <= r[5:3];
    cond = bl_m ? 2'h3 : |al_m ? 2'h2 : |st_m ? 2'h1 : 2'h0;
    axi_rd(thd_pkg::A_STAT, d, rs);
    chk("status", {rs, d[16:0]}, {2'h0, bl_m, 1'b0, al_m, 1'b0, st_m, 1'b0, mode_m[2:0], 2'h0, cond});
    e = r[12:11] % 3;
    case (r[10:8])
      3'h0: begin
        dis_m = r[13:11];
        axi_wr(thd_pkg::A_DIS, dis_m, 2'h0);
      end
      3'h1: begin
        mode_m = r[15:11] % 5 + 1;
        axi_wr(thd_pkg::A_MODE, mode_m, 2'h0);
      end
      3'h2: begin
        test_m = 12 | r[12:11];
        axi_wr(thd_pkg::A_TEST, test_m, 2'h0);
      end
      3'h3: begin
        thr_m[e] = 900 + r[31:16] % 201;
        axi_wr(thd_pkg::A_THR0 + 8'(4 * e), thr_m[e], 2'h0);
      end
      default: ;
    endcase
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Reset values of every setting plus the idle status word
  logic [7:0]  adr[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] dft[11] = '{1, 1, 0, 1000, 1000, 1000, 2000, 2000, 2000, 12, 32'h10};

  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    foreach (h[c]) h[c] = 32'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adr[k]) begin
      axi_rd(adr[k], d, rs);
      chk("default", {rs, d}, {2'h0, dft[k]});
    end
    wr_rd(thd_pkg::A_MODE, 6, 1, 2'h0);
    wr_rd(thd_pkg::A_MAG, 3, 1, 2'h0);
    wr_rd(thd_pkg::A_STAT, 32'hFFFFFFFF, 32'h10, 2'h0);
    wr_rd(8'hFC, 5, 0, thd_pkg::RESP_SLVERR);
    wr_rd(thd_pkg::A_DLY0, thd_pkg::DLY_MAX + 1, thd_pkg::DLY_RST, 2'h0);
    wr_rd(thd_pkg::A_DLY0, thd_pkg::DLY_MAX, thd_pkg::DLY_MAX, 2'h0);
    for (int e = 0; e < 3; e++) axi_wr(thd_pkg::A_DLY0 + 8'(4 * e), dly_m[e], 2'h0);
    repeat (60) step();
    wr_rd(thd_pkg::A_MAG, 2, 2, 2'h0);
    mag_m = 2;
    repeat (60) step();
    repeat (10) @(posedge aclk);
    axi_rd(thd_pkg::A_LCNT, d, rs);
    chk("log count", {rs, d}, {2'h0, 32'((ons > 12) ? 12 : ons)});
    for (int k = 0; k < 3; k++) begin
      axi_rd(thd_pkg::A_CNT0 + 8'(4 * k), d, rs);
      chk("counter", {rs, d}, {2'h0, 32'(onk[k])});
      chk("on events", ev_on[k], onk[k]);
    end
    tally_and_finish();
  end

  // Whole run is near 130 ticks of PER cycles
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
